/* File: pkg/loop_tx_pkg.sv */
/*
  Shared constants for the loop transmitter control register bank:
  command addresses, storage indices, field positions, reset values,
  lookup tables and the access state encoding.
  Assumes every user imports the whole package.
*/
package loop_tx_pkg;

  // Command and register addresses on the control port
  localparam logic [7:0] ADDR_GENERAL_RESET = 8'h01;
  localparam logic [7:0] ADDR_FWD_GAIN      = 8'h05;
  localparam logic [7:0] ADDR_FBK_GAIN      = 8'h06;
  localparam logic [7:0] ADDR_AUX           = 8'h07;
  localparam logic [7:0] ADDR_FREQ          = 8'h08;
  localparam logic [7:0] ADDR_GAIN_RB       = 8'hF4;
  localparam logic [7:0] ADDR_FWD_RB        = 8'hF5;
  localparam logic [7:0] ADDR_FBK_RB        = 8'hF6;
  localparam logic [7:0] ADDR_AUX_RB        = 8'hF7;
  localparam logic [7:0] ADDR_FREQ_RB       = 8'hF8;

  // Storage entries; the two gain halves form the wide gain register
  localparam int         ENTRY_COUNT = 4;
  localparam logic [1:0] IDX_FWD     = 2'h0;
  localparam logic [1:0] IDX_FBK     = 2'h1;
  localparam logic [1:0] IDX_AUX     = 2'h2;
  localparam logic [1:0] IDX_FREQ    = 2'h3;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  // Gain field positions inside their bytes
  localparam int FWD_ATTEN_HI = 7;
  localparam int FWD_ATTEN_LO = 3;
  localparam int FBK_ATTEN_HI = 6;
  localparam int FBK_ATTEN_LO = 0;

  // Auxiliary field positions
  localparam int AUX_OFFSET_POWER_BIT = 7;
  localparam int AUX_INSTAB_POWER_BIT = 6;
  localparam int AUX_RF_POWER_BIT     = 5;
  localparam int AUX_MEAS_SELECT_BIT  = 4;
  localparam int AUX_DET_GAIN_HI      = 3;
  localparam int AUX_DET_GAIN_LO      = 2;
  localparam int AUX_PAIR_HI          = 1;
  localparam int AUX_PAIR_LO          = 0;

  // Frequency field positions and band codes
  localparam int         FREQ_LO_DIV_BIT = 4;
  localparam int         FREQ_BAND_HI    = 1;
  localparam int         FREQ_BAND_LO    = 0;
  localparam logic [1:0] BAND_BELOW_500  = 2'h0;
  localparam logic [1:0] BAND_ABOVE_500  = 2'h1;

  // Reserved positions that the host is expected to leave at zero
  localparam logic [7:0] FWD_RESERVED_MASK  = 8'h07;
  localparam logic [7:0] FBK_RESERVED_MASK  = 8'h80;
  localparam logic [7:0] FREQ_RESERVED_MASK = 8'hEC;

  // Detector gain in dB per code: 6, 12, 18, 24
  localparam logic [7:0] DET_GAIN_DB [4] = '{8'h06, 8'h0C, 8'h12, 8'h18};

  // Pin connections per pair code, bits {q_pos, q_neg, i_pos, i_neg}
  localparam logic [3:0] PAIR_PINS [4] = '{4'h4, 4'h1, 4'h3, 4'hC};

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'h1,
    ST_ACCESS = 2'h2
  } access_state_t;

endpackage

/* File: pkg/reg_bank_if.sv */
/*
  Carrier between the access controller, the storage and the read-back
  selector. Assumes a single clock shared by all three.
*/
`timescale 1ns/1ps
`default_nettype none
interface reg_bank_if;
  logic        wr_en;
  logic [1:0]  wr_index;
  logic [7:0]  wr_data;
  logic        clear_all;
  logic [7:0]  entry [4];
  logic [7:0]  rd_addr;
  logic [15:0] rd_data;
  logic        rd_hit;

  modport ctrl  (output wr_en, wr_index, wr_data, clear_all, rd_addr,
                 input entry, rd_data, rd_hit);
  modport store (input wr_en, wr_index, wr_data, clear_all, output entry);
  modport view  (input entry, rd_addr, output rd_data, rd_hit);
endinterface
`default_nettype wire

/* File: src/control_store.sv */
/*
  Flip-flop storage for the four control bytes, addressed by index.
  Assumes one write strobe at a time from the access controller.
*/
`timescale 1ns/1ps
`default_nettype none
module control_store
  import loop_tx_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  reg_bank_if.store  bank
);
  genvar gi;
  generate
    for (gi = 0; gi < ENTRY_COUNT; gi++)
    begin : g_entry
      always_ff @(posedge clk)
      begin
        if (!rst_n || bank.clear_all)
          bank.entry[gi] <= BYTE_RESET;
        else if (bank.wr_en && bank.wr_index == 2'(gi))
          bank.entry[gi] <= bank.wr_data;
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: src/readback_select.sv */
/*
  Read-back selector: maps a read address onto the stored bytes.
  Assumes the storage holds the two gain halves as the wide register.
*/
`timescale 1ns/1ps
`default_nettype none
module readback_select
  import loop_tx_pkg::*;
(
  reg_bank_if.view bank
);
  always_comb
  begin
    bank.rd_hit  = 1'b1;
    bank.rd_data = 16'h0000;
    case (bank.rd_addr)
      ADDR_GAIN_RB: bank.rd_data = {bank.entry[IDX_FWD], bank.entry[IDX_FBK]};
      ADDR_FWD_RB:  bank.rd_data = {8'h00, bank.entry[IDX_FWD]};
      ADDR_FBK_RB:  bank.rd_data = {8'h00, bank.entry[IDX_FBK]};
      ADDR_AUX_RB:  bank.rd_data = {8'h00, bank.entry[IDX_AUX]};
      ADDR_FREQ_RB: bank.rd_data = {8'h00, bank.entry[IDX_FREQ]};
      default:      bank.rd_hit  = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: src/loop_tx_aux_gain_freq_regs.sv */
/*
  Control register bank of a feedback-loop transmitter: gain halves,
  auxiliary and frequency registers, their read-back mirrors and the
  decoded control levels that steer the analogue sections.
  Assumes a deserialised control port: one-cycle read or write strobes
  with address and data, synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module loop_tx_aux_gain_freq_regs
  import loop_tx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_done,
  output logic             cmd_error,
  output logic             cmd_busy,
  output logic [4:0]       forward_atten,
  output logic [6:0]       feedback_atten,
  output logic             offset_meas_power,
  output logic             instab_detector_power,
  output logic             rf_detector_power,
  output logic             measurement_output_select,
  output logic [1:0]       detector_gain_code,
  output logic [7:0]       detector_gain_db,
  output logic [1:0]       meas_pair_select,
  output logic [3:0]       meas_pin_connect,
  output logic             lo_divide_by_four,
  output logic [1:0]       loop_band,
  output logic             loop_above_500,
  output logic             band_code_reserved,
  output logic             reserved_bits_set,
  output logic             aux_circuits_off
);

  reg_bank_if bank ();

  access_state_t state;
  access_state_t next_state;
  logic [7:0]    held_addr;
  logic [15:0]   held_data;
  logic          held_write;
  logic          take_request;
  logic          write_map_hit;
  logic [1:0]    write_index;
  logic          is_reset_cmd;
  logic [7:0]    fwd_byte;
  logic [7:0]    fbk_byte;
  logic [7:0]    aux_byte;
  logic [7:0]    freq_byte;

  control_store u_store
  (
    .clk   (clk),
    .rst_n (rst_n),
    .bank  (bank)
  );

  readback_select u_readback
  (
    .bank (bank)
  );

  assign fwd_byte  = bank.entry[IDX_FWD];
  assign fbk_byte  = bank.entry[IDX_FBK];
  assign aux_byte  = bank.entry[IDX_AUX];
  assign freq_byte = bank.entry[IDX_FREQ];

  // Requests arriving while an access is in flight are dropped
  assign take_request = (state == ST_IDLE) && (cmd_write || cmd_read);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (take_request)
          next_state = ST_ACCESS;
      end
      ST_ACCESS:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Request capture; write wins if both strobes arrive together
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      held_addr  <= 8'h00;
      held_data  <= 16'h0000;
      held_write <= 1'b0;
    end
    else if (take_request)
    begin
      held_addr  <= cmd_addr;
      held_data  <= cmd_wdata;
      held_write <= cmd_write;
    end
  end

  // Write address decode onto storage entries
  always_comb
  begin
    write_map_hit = 1'b1;
    write_index   = IDX_FWD;
    is_reset_cmd  = 1'b0;
    case (held_addr)
      ADDR_FWD_GAIN:      write_index = IDX_FWD;
      ADDR_FBK_GAIN:      write_index = IDX_FBK;
      ADDR_AUX:           write_index = IDX_AUX;
      ADDR_FREQ:          write_index = IDX_FREQ;
      ADDR_GENERAL_RESET: is_reset_cmd = 1'b1;
      default:            write_map_hit = 1'b0;
    endcase
  end

  // Storage strobes are only live for the one access cycle
  assign bank.wr_en     = (state == ST_ACCESS) && held_write && write_map_hit && !is_reset_cmd;
  assign bank.wr_index  = write_index;
  assign bank.wr_data   = held_data[7:0];
  assign bank.clear_all = (state == ST_ACCESS) && held_write && is_reset_cmd;
  assign bank.rd_addr   = held_addr;

  // Answer: data and done pulse one edge after the access cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmd_rdata <= 16'h0000;
      cmd_done  <= 1'b0;
      cmd_error <= 1'b0;
    end
    else if (state == ST_ACCESS)
    begin
      cmd_done  <= 1'b1;
      cmd_rdata <= held_write ? 16'h0000 : bank.rd_data;
      cmd_error <= held_write ? !write_map_hit : !bank.rd_hit;
    end
    else
    begin
      cmd_done  <= 1'b0;
      cmd_error <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmd_busy <= 1'b0;
    else
      cmd_busy <= (next_state != ST_IDLE);
  end

  // Gain fields; reserved bits are kept in storage but not decoded
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      forward_atten  <= 5'h00;
      feedback_atten <= 7'h00;
    end
    else
    begin
      forward_atten  <= fwd_byte[FWD_ATTEN_HI:FWD_ATTEN_LO];
      feedback_atten <= fbk_byte[FBK_ATTEN_HI:FBK_ATTEN_LO];
    end
  end

  // Auxiliary power enables
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      offset_meas_power     <= 1'b0;
      instab_detector_power <= 1'b0;
      rf_detector_power     <= 1'b0;
      aux_circuits_off      <= 1'b1;
    end
    else
    begin
      offset_meas_power     <= aux_byte[AUX_OFFSET_POWER_BIT];
      instab_detector_power <= aux_byte[AUX_INSTAB_POWER_BIT];
      rf_detector_power     <= aux_byte[AUX_RF_POWER_BIT];
      aux_circuits_off      <= !(aux_byte[AUX_OFFSET_POWER_BIT]
                                 || aux_byte[AUX_INSTAB_POWER_BIT]
                                 || aux_byte[AUX_RF_POWER_BIT]);
    end
  end

  // Measurement routing and detector gain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      measurement_output_select <= 1'b0;
      detector_gain_code        <= 2'h0;
      detector_gain_db          <= DET_GAIN_DB[0];
    end
    else
    begin
      measurement_output_select <= aux_byte[AUX_MEAS_SELECT_BIT];
      detector_gain_code        <= aux_byte[AUX_DET_GAIN_HI:AUX_DET_GAIN_LO];
      detector_gain_db          <=
        DET_GAIN_DB[aux_byte[AUX_DET_GAIN_HI:AUX_DET_GAIN_LO]];
    end
  end

  // Pair table copies the printed pairings, four distinct entries
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meas_pair_select <= 2'h0;
      meas_pin_connect <= PAIR_PINS[0];
    end
    else
    begin
      meas_pair_select <= aux_byte[AUX_PAIR_HI:AUX_PAIR_LO];
      meas_pin_connect <= PAIR_PINS[aux_byte[AUX_PAIR_HI:AUX_PAIR_LO]];
    end
  end

  // Divider and band; reserved band codes pass into loop_band and keep loop_above_500 low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lo_divide_by_four  <= 1'b0;
      loop_band          <= BAND_BELOW_500;
      loop_above_500     <= 1'b0;
      band_code_reserved <= 1'b0;
    end
    else
    begin
      lo_divide_by_four  <= freq_byte[FREQ_LO_DIV_BIT];
      loop_band          <= freq_byte[FREQ_BAND_HI:FREQ_BAND_LO];
      loop_above_500     <= (freq_byte[FREQ_BAND_HI:FREQ_BAND_LO] == BAND_ABOVE_500);
      band_code_reserved <= freq_byte[FREQ_BAND_HI];
    end
  end

  // Level flag only: nonzero reserved bits are kept, never masked
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reserved_bits_set <= 1'b0;
    else
      reserved_bits_set <= |(fwd_byte & FWD_RESERVED_MASK)
                           || |(fbk_byte & FBK_RESERVED_MASK)
                           || |(freq_byte & FREQ_RESERVED_MASK);
  end

endmodule
`default_nettype wire

/* File: verif/loop_tx_regs_monitor.sv */
/*
  Checker for the loop transmitter register bank, bound to its top.
  Assumes strobes are taken only while cmd_busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module loop_tx_regs_monitor
  import loop_tx_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cmd_write,
  input wire logic        cmd_read,
  input wire logic [7:0]  cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic        cmd_done,
  input wire logic        cmd_busy,
  input wire logic [4:0]  forward_atten,
  input wire logic [6:0]  feedback_atten,
  input wire logic        offset_meas_power,
  input wire logic        instab_detector_power,
  input wire logic        rf_detector_power,
  input wire logic        measurement_output_select,
  input wire logic [1:0]  detector_gain_code,
  input wire logic [7:0]  detector_gain_db,
  input wire logic [1:0]  meas_pair_select,
  input wire logic [3:0]  meas_pin_connect,
  input wire logic        lo_divide_by_four,
  input wire logic [1:0]  loop_band,
  input wire logic        loop_above_500,
  input wire logic        band_code_reserved,
  input wire logic        aux_circuits_off
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_take;
    (cmd_write || cmd_read) && !cmd_busy;
  endsequence
  sequence s_answer;
    cmd_busy ##1 (cmd_done && !cmd_busy);
  endsequence
  sequence s_wr(logic [7:0] a);
    cmd_write && !cmd_busy && cmd_addr == a;
  endsequence

  chk_answer_timing: assert property (s_take |=> s_answer)
    else $error("answer not one cycle after busy");
  chk_fwd_field: assert property (s_wr(ADDR_FWD_GAIN) |-> ##3
    forward_atten == $past(cmd_wdata[7:3], 3))
    else $error("forward attenuation not from written byte");
  chk_fbk_field: assert property (s_wr(ADDR_FBK_GAIN) |-> ##3
    feedback_atten == $past(cmd_wdata[6:0], 3))
    else $error("feedback attenuation not from written byte");
  chk_aux_power: assert property (s_wr(ADDR_AUX) |-> ##3
    {offset_meas_power, instab_detector_power, rf_detector_power} == $past(cmd_wdata[7:5], 3))
    else $error("power enables not from auxiliary byte");
  chk_aux_route: assert property (s_wr(ADDR_AUX) |-> ##3
    {measurement_output_select, detector_gain_code, meas_pair_select}
    == $past(cmd_wdata[4:0], 3))
    else $error("routing or gain code not from auxiliary byte");
  chk_gain_db: assert property (detector_gain_db ==
    8'h06 * ({6'h00, detector_gain_code} + 8'h01))
    else $error("detector gain in dB wrong");
  chk_pair_pins: assert property (meas_pin_connect ==
    (meas_pair_select == 2'h0 ? 4'h4 :
    meas_pair_select == 2'h1 ? 4'h1 : meas_pair_select == 2'h2 ? 4'h3 : 4'hC))
    else $error("pin pairing wrong");
  chk_freq_fields: assert property (s_wr(ADDR_FREQ) |-> ##3
    lo_divide_by_four == $past(cmd_wdata[4], 3) && loop_band == $past(cmd_wdata[1:0], 3))
    else $error("frequency fields not from written byte");
  chk_band_decode: assert property (loop_above_500 == (loop_band == 2'h1)
    && band_code_reserved == loop_band[1])
    else $error("band decode wrong");
  chk_pin_reset: assert property (disable iff (1'b0) !rst_n |=> forward_atten == 5'h00
    && feedback_atten == 7'h00 && aux_circuits_off && loop_band == 2'h0)
    else $error("reset pin did not clear controls");
  chk_cmd_reset: assert property (s_wr(ADDR_GENERAL_RESET) |-> ##3
    forward_atten == 5'h00 && feedback_atten == 7'h00 && aux_circuits_off && !lo_divide_by_four)
    else $error("reset command did not clear controls");
endmodule

bind loop_tx_aux_gain_freq_regs loop_tx_regs_monitor i_loop_tx_regs_monitor
(
  .clk(clk), .rst_n(rst_n), .cmd_write(cmd_write), .cmd_read(cmd_read),
  .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_busy(cmd_busy),
  .forward_atten(forward_atten), .feedback_atten(feedback_atten),
  .offset_meas_power(offset_meas_power), .instab_detector_power(instab_detector_power),
  .rf_detector_power(rf_detector_power), .measurement_output_select(measurement_output_select),
  .detector_gain_code(detector_gain_code), .detector_gain_db(detector_gain_db),
  .meas_pair_select(meas_pair_select), .meas_pin_connect(meas_pin_connect),
  .lo_divide_by_four(lo_divide_by_four), .loop_band(loop_band),
  .loop_above_500(loop_above_500), .band_code_reserved(band_code_reserved),
  .aux_circuits_off(aux_circuits_off)
);
`default_nettype wire

/* File: verif/host_model.sv */
/*
  Host controller model: one strobed access at a time on the control port.
  Assumes the answer arrives within four cycles of the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model
  import loop_tx_pkg::*;
(
  input  wire logic        clk,
  output var logic         cmd_write,
  output var logic         cmd_read,
  output var logic [7:0]   cmd_addr,
  output var logic [15:0]  cmd_wdata,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_done,
  input  wire logic        cmd_error
);
  initial
  begin
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Raw access skips the masking, only for reserved-bit scenarios
  task automatic access(input logic wr, input logic raw, input logic [7:0] a,
    input logic [7:0] d, output logic [15:0] rd, output logic er, output logic ok);
    logic [7:0] v;
    v = d;
    if (!raw && a == ADDR_FWD_GAIN)
      v = d & 8'hF8;
    if (!raw && a == ADDR_FBK_GAIN)
      v = d & 8'h7F;
    if (!raw && a == ADDR_FREQ)
      v = d & 8'h11;
    ok = 1'b0;
    @(posedge clk);
    #1;
    cmd_write = wr;
    cmd_read = !wr;
    cmd_addr = a;
    cmd_wdata = {8'h00, v};
    @(posedge clk);
    #1;
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk);
      #1;
      if (cmd_done === 1'b1)
      begin
        ok = 1'b1;
        rd = cmd_rdata;
        er = cmd_error;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/loop_tx_aux_gain_freq_regs_tb.sv */
/*
  Self-checking bench for the loop transmitter register bank.
  Assumes the host model and the bound checker sit beside the design.
*/
`timescale 1ns/1ps
`default_nettype none
module loop_tx_aux_gain_freq_regs_tb
  import loop_tx_pkg::*;
;
  typedef struct packed {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [15:0] rd;} row_t;
  localparam row_t ROWS [11] = '{
    '{8'h05, 8'hF8, 8'hF5, 16'h00F8}, '{8'h06, 8'h7F, 8'hF4, 16'hF87F},
    '{8'h07, 8'h00, 8'hF7, 16'h0000}, '{8'h07, 8'h55, 8'hF7, 16'h0055},
    '{8'h07, 8'hAA, 8'hF7, 16'h00AA}, '{8'h07, 8'hFF, 8'hF7, 16'h00FF},
    '{8'h08, 8'h10, 8'hF8, 16'h0010}, '{8'h08, 8'h01, 8'hF8, 16'h0001},
    '{8'h08, 8'h11, 8'hF8, 16'h0011}, '{8'h05, 8'h08, 8'hF4, 16'h087F},
    '{8'h06, 8'h2A, 8'hF6, 16'h002A}};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  int          fail_count = 0;
  int          checks = 0;
  wire         cmd_write;
  wire         cmd_read;
  wire  [7:0]  cmd_addr;
  wire  [15:0] cmd_wdata;
  wire  [15:0] cmd_rdata;
  wire         cmd_done;
  wire         cmd_error;
  wire  [7:0]  detector_gain_db;
  wire         loop_above_500;
  wire         band_code_reserved;
  wire         reserved_bits_set;
  wire         aux_circuits_off;

  always #5 clk = ~clk;

  host_model i_host_model (.clk(clk), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_done(cmd_done), .cmd_error(cmd_error));

  loop_tx_aux_gain_freq_regs i_loop_tx_aux_gain_freq_regs (.clk(clk), .rst_n(rst_n),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_done(cmd_done), .cmd_error(cmd_error), .cmd_busy(),
    .forward_atten(), .feedback_atten(), .offset_meas_power(), .instab_detector_power(),
    .rf_detector_power(), .measurement_output_select(), .detector_gain_code(),
    .detector_gain_db(detector_gain_db), .meas_pair_select(), .meas_pin_connect(),
    .lo_divide_by_four(), .loop_band(), .loop_above_500(loop_above_500),
    .band_code_reserved(band_code_reserved), .reserved_bits_set(reserved_bits_set),
    .aux_circuits_off(aux_circuits_off));

  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Read data is only compared on accepted reads; refused ones carry no data
  task automatic acc(input logic wr, input logic raw, input logic [7:0] a, input logic [7:0] d,
    input logic xe, input logic [15:0] xr);
    logic [15:0] rd;
    logic        er;
    logic        ok;
    i_host_model.access(wr, raw, a, d, rd, er, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("CHECK FAILED cmd_done expected 1 seen 0");
      report_and_stop();
    end
    chk("cmd_error", {15'h0000, xe}, {15'h0000, er});
    if (!wr && !xe)
      chk("cmd_rdata", xr, rd);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    acc(1'b0, 1'b0, 8'hF4, 8'h00, 1'b0, 16'h0000);
    chk("aux_circuits_off", 16'h0001, {15'h0000, aux_circuits_off});
    chk("detector_gain_db", 16'h0006, {8'h00, detector_gain_db});
    foreach (ROWS[i])
    begin
      acc(1'b1, 1'b0, ROWS[i].wa, ROWS[i].wd, 1'b0, 16'h0000);
      acc(1'b0, 1'b0, ROWS[i].ra, 8'h00, 1'b0, ROWS[i].rd);
    end
    acc(1'b1, 1'b1, 8'h05, 8'hFF, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, 8'hF4, 8'h00, 1'b0, 16'hFF2A);
    chk("reserved_bits_set", 16'h0001, {15'h0000, reserved_bits_set});
    acc(1'b1, 1'b1, 8'h08, 8'h02, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, 8'hF8, 8'h00, 1'b0, 16'h0002);
    chk("band_reserved", 16'h0001, {15'h0000, band_code_reserved});
    chk("loop_above_500", 16'h0000, {15'h0000, loop_above_500});
    acc(1'b0, 1'b0, 8'h05, 8'h00, 1'b1, 16'h0000);
    acc(1'b1, 1'b0, 8'hF4, 8'h5A, 1'b1, 16'h0000);
    acc(1'b0, 1'b0, 8'h01, 8'h00, 1'b1, 16'h0000);
    acc(1'b1, 1'b0, 8'h01, 8'h00, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, 8'hF4, 8'h00, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, 8'hF7, 8'h00, 1'b0, 16'h0000);
    chk("aux_circuits_off", 16'h0001, {15'h0000, aux_circuits_off});
    acc(1'b1, 1'b0, 8'h07, 8'hE0, 1'b0, 16'h0000);
    // Mid-run pin reset must clear what the command did not touch
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    acc(1'b0, 1'b0, 8'hF7, 8'h00, 1'b0, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
